// ---- hw/uhrc_pkg.sv ----
package uhrc_pkg;
    // ==============================
    // Clock and link timing
    // ==============================
    localparam int CLK_HZ = 10_000_000;
    localparam int FRAME_US = 1000;
    // One frame period in clock cycles
    localparam int FRAME_CYC = (CLK_HZ / 1_000_000) * FRAME_US;
    localparam int LINK_BPS = 12_000_000;
    localparam int DETECT_BITS = 64;
    // Rounded down, as the detect delay is only approximate
    localparam int DETECT_CYC = (DETECT_BITS * (CLK_HZ / 1000)) / (LINK_BPS / 1000);
    localparam int HCRST_CYC = 8;
    localparam int NPORTS = 2;
    localparam int FRIDX_W = 11;
    localparam int FCNT_W = 14;
    // ==============================
    // Command register layout
    // ==============================
    localparam int CMD_W = 16;
    localparam logic [CMD_W-1:0] CMD_RESET = 16'h0000;
    localparam int B_RS = 0;
    localparam int B_HCRST = 1;
    localparam int B_GRST = 2;
    localparam int B_GLOBAL_SUSPEND_ENTER = 3;
    localparam int B_FGR = 4;
    localparam int B_DBG = 5;
    localparam int B_CF = 6;
    localparam int B_MAXP = 7;
    // ==============================
    // Run control states
    // ==============================
    typedef enum logic [2:0] {
        ST_HALTED = 3'b001,
        ST_RUN = 3'b010,
        ST_DRAIN = 3'b100
    } uhrc_state_t;
endpackage

// ---- hw/uhrc_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module uhrc_port
    import uhrc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_hc_reset,
    input wire logic i_attach,
    input wire logic i_lowspeed,
    input wire logic i_en_wr,
    input wire logic i_en_val,
    input wire logic i_cc_clr,
    input wire logic i_ec_clr,
    output logic o_connect,
    output logic o_conn_chg,
    output logic o_enable,
    output logic o_en_chg,
    output logic o_lowspeed,
    output logic o_evt
);
    // ==============================
    // Pin synchronisers
    // ==============================
    logic [2:0] att_s_q;
    logic [2:0] ls_s_q;
    logic att_q;
    logic ls_q;
    logic wait_q;
    logic [5:0] det_q;
    logic hold;
    logic conn_d;
    logic ls_d;
    logic chg;
    logic drop;

    // Filtered level moves only when second and third stage agree
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            att_s_q <= 3'h0;
            ls_s_q <= 3'h0;
            att_q <= 1'b0;
            ls_q <= 1'b0;
        end else begin
            att_s_q <= {att_s_q[1:0], i_attach};
            ls_s_q <= {ls_s_q[1:0], i_lowspeed};
            if (att_s_q[1] == att_s_q[2]) att_q <= att_s_q[2];
            if (ls_s_q[1] == ls_s_q[2]) ls_q <= ls_s_q[2];
        end
    end

    // ==============================
    // Connect/disconnect machine
    // ==============================
    // Soft reset forces a virtual disconnect until detection reruns
    assign hold = i_hc_reset | wait_q;
    assign conn_d = hold ? 1'b0 : att_q;
    assign ls_d = hold ? 1'b0 : ls_q;
    assign chg = conn_d != o_connect;
    assign drop = o_enable & ~conn_d;

    // Detection delay counted from the fall of soft reset
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            wait_q <= 1'b0;
            det_q <= 6'h00;
        end else if (i_hc_reset) begin
            wait_q <= 1'b1;
            det_q <= 6'h00;
        end else if (wait_q) begin
            det_q <= det_q + 6'h01;
            if (det_q == 6'(DETECT_CYC - 1)) wait_q <= 1'b0;
        end
    end

    // Change flags: a hardware set beats a same-cycle clear
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_connect <= 1'b0;
            o_lowspeed <= 1'b0;
            o_enable <= 1'b0;
            o_conn_chg <= 1'b0;
            o_en_chg <= 1'b0;
            o_evt <= 1'b0;
        end else begin
            o_connect <= conn_d;
            o_lowspeed <= ls_d;
            o_enable <= conn_d & (i_en_wr ? i_en_val : o_enable);
            o_conn_chg <= (o_conn_chg & ~i_cc_clr) | chg | i_hc_reset;
            o_en_chg <= (o_en_chg & ~i_ec_clr) | drop | i_hc_reset;
            o_evt <= chg & ~hold;
        end
    end
endmodule
`default_nettype wire

// ---- hw/uhrc_top.sv ----
// Summary of operation
// - Suspend bit blocks all bus transactions
// - Resume still detected and signalled in suspend
// - Global reset signals bus, resets all logic
// - Chip reset acts alike without bus signalling
// - Soft reset restarts counters, aborts transaction
// - Soft reset bit clears itself when done
// - Soft reset virtually disconnects every port
// - Disconnect sets change flags, clears low speed
// - Ports redetect 64 bit times after reset
// - Run bit keeps schedule executing
// - Stop finishes transaction then shows halted
// - Fatal errors clear run bit
// - Normal stop resets frame counter, index writable
// - Normal run restarts at start of frame
// - Debug stop freezes counter, resumes in place
// - Debug run executes one descriptor, halts
// - Suspend resume events set force resume
// - Halted flag set after any stop
`timescale 1ns/1ps
`default_nettype none
module uhrc_top
    import uhrc_pkg::*;
#(
    parameter int FRAME_CYCLES = FRAME_CYC
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_cmd_wr,
    input wire logic [CMD_W-1:0] i_cmd_wdata,
    output logic [CMD_W-1:0] o_cmd_rdata,
    input wire logic i_frame_index_reg_wr,
    input wire logic [CMD_W-1:0] i_frame_index_reg_wdata,
    output logic [FRIDX_W-1:0] o_frame_index,
    output logic o_halted,
    input wire logic i_txn_active,
    input wire logic i_td_fetch,
    input wire logic i_err_consist,
    input wire logic i_err_pci,
    output logic o_sched_run,
    output logic o_sof,
    output logic o_txn_abort,
    output logic o_usb_reset,
    output logic o_global_resume,
    output logic o_resume_irq,
    output logic o_suspended,
    input wire logic i_k_state,
    input wire logic [NPORTS-1:0] i_port_attach,
    input wire logic [NPORTS-1:0] i_port_lowspeed,
    input wire logic [NPORTS-1:0] i_port_en_wr,
    input wire logic [NPORTS-1:0] i_port_en_val,
    input wire logic [NPORTS-1:0] i_port_cc_clr,
    input wire logic [NPORTS-1:0] i_port_ec_clr,
    output logic [NPORTS-1:0] o_port_connect,
    output logic [NPORTS-1:0] o_port_conn_chg,
    output logic [NPORTS-1:0] o_port_enable,
    output logic [NPORTS-1:0] o_port_en_chg,
    output logic [NPORTS-1:0] o_port_lowspeed
);
    // ==============================
    // Declarations
    // ==============================
    logic run_q;
    logic hcrst_q;
    logic grst_q;
    logic global_suspend_enter_q;
    logic fgr_q;
    logic dbg_q;
    logic cf_q;
    logic maxp_q;
    logic [3:0] hcrst_cnt_q;
    logic [2:0] k_s_q;
    logic k_q;
    logic k_prev_q;
    logic [NPORTS-1:0] port_evt;
    logic [FCNT_W-1:0] fcnt_q;
    uhrc_state_t state_q;
    uhrc_state_t state_d;
    logic core_rst;
    logic wr;
    logic hw_stop;
    logic step_stop;
    logic run_d;
    logic fgr_d;
    logic k_rise;
    logic resume_evt;
    logic hcrst_done;
    logic frame_end;
    logic restart;
    logic can_run;
    logic fidx_wr;
    logic hcrst_start;
    logic sof_d;
    logic sched_d;
    logic halted_d;
    logic usb_rst_d;
    logic [CMD_W-1:0] cmd_word;

    // ==============================
    // Reset and write decode
    // ==============================
    // Global reset clears what chip reset does, save grst_q, o_usb_reset and o_cmd_rdata
    assign core_rst = i_rst | grst_q;
    assign wr = i_cmd_wr;
    assign hcrst_done = hcrst_q & (hcrst_cnt_q == 4'(HCRST_CYC - 1));

    // ==============================
    // Run bit control
    // ==============================
    // Hardware clears on fatal errors; this beats a same-cycle write
    assign hw_stop = i_err_consist | i_err_pci;
    // Single step: run drops as the descriptor is fetched
    assign step_stop = dbg_q & run_q & i_td_fetch;
    assign run_d = (wr ? i_cmd_wdata[B_RS] : run_q)
        & ~hw_stop & ~step_stop & ~hcrst_q;

    // ==============================
    // Resume detection in suspend
    // ==============================
    assign k_rise = k_q & ~k_prev_q;
    assign resume_evt = global_suspend_enter_q & (k_rise | (|port_evt));
    // Hardware set beats a same-cycle software clear
    assign fgr_d = (wr ? i_cmd_wdata[B_FGR] : fgr_q) | resume_evt;

    // K-state pin passes three stages; act once stages two and three agree
    always_ff @(posedge i_clock) begin
        if (core_rst) begin
            k_s_q <= 3'h0;
            k_q <= 1'b0;
            k_prev_q <= 1'b0;
        end else begin
            k_s_q <= {k_s_q[1:0], i_k_state};
            if (k_s_q[1] == k_s_q[2]) k_q <= k_s_q[2];
            k_prev_q <= k_q;
        end
    end

    // ==============================
    // Global reset bit
    // ==============================
    // Only chip reset clears it; software must release it itself
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            grst_q <= CMD_RESET[B_GRST];
        end else if (wr) begin
            grst_q <= i_cmd_wdata[B_GRST];
        end
    end

    // ==============================
    // Command register bits
    // ==============================
    // Debug mode is only sampled from software writes; software keeps
    // it stable while running, so no interlock is spent on it
    always_ff @(posedge i_clock) begin
        if (core_rst) begin
            run_q <= CMD_RESET[B_RS];
            global_suspend_enter_q <= CMD_RESET[B_GLOBAL_SUSPEND_ENTER];
            fgr_q <= CMD_RESET[B_FGR];
            dbg_q <= CMD_RESET[B_DBG];
            cf_q <= CMD_RESET[B_CF];
            maxp_q <= CMD_RESET[B_MAXP];
        end else begin
            run_q <= run_d;
            fgr_q <= fgr_d;
            if (wr) begin
                global_suspend_enter_q <= i_cmd_wdata[B_GLOBAL_SUSPEND_ENTER];
                dbg_q <= i_cmd_wdata[B_DBG];
                cf_q <= i_cmd_wdata[B_CF];
                maxp_q <= i_cmd_wdata[B_MAXP];
            end
        end
    end

    // ==============================
    // Controller soft reset sequence
    // ==============================
    // Requests during a running sequence are dropped, not queued
    assign hcrst_start = wr & i_cmd_wdata[B_HCRST] & ~hcrst_q;

    // Fixed-length sequence, then the bit drops by itself
    always_ff @(posedge i_clock) begin
        if (core_rst) begin
            hcrst_q <= CMD_RESET[B_HCRST];
            hcrst_cnt_q <= 4'h0;
        end else if (hcrst_done) begin
            hcrst_q <= 1'b0;
            hcrst_cnt_q <= 4'h0;
        end else if (hcrst_q) begin
            hcrst_cnt_q <= hcrst_cnt_q + 4'h1;
        end else if (hcrst_start) begin
            hcrst_q <= 1'b1;
        end
    end

    // ==============================
    // Run/stop state machine
    // ==============================
    // Suspend holds the schedule even if software left run set
    assign can_run = run_q & ~global_suspend_enter_q & ~hcrst_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_HALTED: begin
                if (can_run) state_d = ST_RUN;
            end
            ST_RUN: begin
                if (!can_run) state_d = ST_DRAIN;
            end
            ST_DRAIN: begin
                if (!i_txn_active) state_d = ST_HALTED;
            end
            default: begin
                state_d = ST_HALTED;
            end
        endcase
        // Soft reset aborts at once instead of draining
        if (hcrst_q) state_d = ST_HALTED;
    end

    always_ff @(posedge i_clock) begin
        if (core_rst) begin
            state_q <= ST_HALTED;
        end else begin
            state_q <= state_d;
        end
    end

    // ==============================
    // Frame counter and frame index
    // ==============================
    // Normal-mode start always begins a fresh frame
    assign restart = (state_q == ST_HALTED) & (state_d == ST_RUN) & ~dbg_q;
    assign frame_end = (state_q != ST_HALTED)
        & (fcnt_q == FCNT_W'(FRAME_CYCLES - 1));
    // Writes are ignored while run is set
    assign fidx_wr = i_frame_index_reg_wr & ~run_q;

    always_ff @(posedge i_clock) begin
        if (core_rst || hcrst_q) begin
            fcnt_q <= '0;
            o_frame_index <= '0;
        end else begin
            if (fidx_wr) begin
                o_frame_index <= i_frame_index_reg_wdata[FRIDX_W-1:0];
            end else if (frame_end) begin
                o_frame_index <= o_frame_index + FRIDX_W'(1);
            end
            if (state_q != ST_HALTED) begin
                fcnt_q <= frame_end ? '0 : fcnt_q + FCNT_W'(1);
            end else if (!dbg_q) begin
                fcnt_q <= '0;
            end
            // In debug mode the halted counter holds its value
        end
    end

    // ==============================
    // Output next-value decode
    // ==============================
    // Decoded here so each output below is a single flop
    assign sof_d = restart | (frame_end & can_run);
    assign sched_d = state_d == ST_RUN;
    assign halted_d = state_d == ST_HALTED;
    // Bus reset follows the bit in its own write cycle
    assign usb_rst_d = wr ? i_cmd_wdata[B_GRST] : grst_q;
    // Command word as software reads it back
    assign cmd_word = {8'h00, maxp_q, cf_q, dbg_q, fgr_q,
        global_suspend_enter_q, grst_q, hcrst_q, run_q};

    // ==============================
    // Registered outputs
    // ==============================
    // Start-of-frame pulse on normal-mode start and on each wrap while can_run holds
    always_ff @(posedge i_clock) begin
        if (core_rst) begin
            o_sof <= 1'b0;
            o_sched_run <= 1'b0;
            o_halted <= 1'b1;
            o_txn_abort <= 1'b0;
            o_resume_irq <= 1'b0;
            o_suspended <= 1'b0;
            o_global_resume <= 1'b0;
        end else begin
            o_sof <= sof_d;
            // New transactions start only while running
            o_sched_run <= sched_d;
            o_halted <= halted_d;
            o_txn_abort <= hcrst_q;
            o_resume_irq <= resume_evt;
            o_suspended <= global_suspend_enter_q;
            o_global_resume <= fgr_d;
        end
    end

    // Bus reset signalling only from the command bit, never chip reset
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_usb_reset <= 1'b0;
        end else begin
            o_usb_reset <= usb_rst_d;
        end
    end

    // Readback of the command word; upper byte reads as zero
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_cmd_rdata <= CMD_RESET;
        end else begin
            o_cmd_rdata <= cmd_word;
        end
    end

    // ==============================
    // Root hub ports
    // ==============================
    for (genvar p = 0; p < NPORTS; p++) begin : g_port
        uhrc_port i_uhrc_port (
            .i_clock(i_clock),
            .i_rst(core_rst),
            .i_hc_reset(hcrst_q),
            .i_attach(i_port_attach[p]),
            .i_lowspeed(i_port_lowspeed[p]),
            .i_en_wr(i_port_en_wr[p]),
            .i_en_val(i_port_en_val[p]),
            .i_cc_clr(i_port_cc_clr[p]),
            .i_ec_clr(i_port_ec_clr[p]),
            .o_connect(o_port_connect[p]),
            .o_conn_chg(o_port_conn_chg[p]),
            .o_enable(o_port_enable[p]),
            .o_en_chg(o_port_en_chg[p]),
            .o_lowspeed(o_port_lowspeed[p]),
            .o_evt(port_evt[p])
        );
    end
endmodule
`default_nettype wire

// ---- testbench/uhrc_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==============================
// Devices on the root ports
// ==============================
module uhrc_dev_model
    import uhrc_pkg::*;
#(
    parameter int SETTLE_CYC = 2,
    parameter int WAKE_CYC = 6
) (
    input wire logic i_clock,
    input wire logic [NPORTS-1:0] i_plug,
    input wire logic [NPORTS-1:0] i_slow,
    input wire logic i_wake,
    output logic [NPORTS-1:0] o_attach,
    output logic [NPORTS-1:0] o_lowspeed,
    output logic o_k_state
);
    int settle = 0;
    int k_left = 0;
    initial o_attach = '0;
    // Unplugged lines are pulled down, so no stale speed shows
    assign o_lowspeed = o_attach & i_slow;
    assign o_k_state = (k_left != 0);
    // Contacts settle before the pins move; wake sends a K burst
    always @(posedge i_clock) begin
        if (i_plug == o_attach) begin
            settle <= 0;
        end else if (settle >= SETTLE_CYC) begin
            o_attach <= i_plug;
        end else begin
            settle <= settle + 1;
        end
        if (i_wake && k_left == 0) begin
            k_left <= WAKE_CYC;
        end else if (k_left != 0) begin
            k_left <= k_left - 1;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/uhrc_run_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==============================
// Run control port checker
// ==============================
module uhrc_run_checker
    import uhrc_pkg::*;
#(
    parameter int FRAME_CYCLES = FRAME_CYC
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [CMD_W-1:0] o_cmd_rdata,
    input wire logic o_halted,
    input wire logic i_txn_active,
    input wire logic i_td_fetch,
    input wire logic i_err_consist,
    input wire logic i_err_pci,
    input wire logic o_sched_run,
    input wire logic o_sof,
    input wire logic o_txn_abort,
    input wire logic o_usb_reset,
    input wire logic o_global_resume,
    input wire logic o_resume_irq,
    input wire logic o_suspended,
    input wire logic [NPORTS-1:0] o_port_connect,
    input wire logic [NPORTS-1:0] o_port_enable,
    input wire logic [NPORTS-1:0] o_port_lowspeed
);
    // One clock domain, chip reset silences every check
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    property p_susp_idle;
        o_suspended && $past(o_suspended) |-> !o_sched_run;
    endproperty
    a_susp_idle: assert property (p_susp_idle)
        else $error("schedule runs in suspend");
    property p_resume;
        o_resume_irq |-> ##[0:2] (o_global_resume && o_suspended);
    endproperty
    a_resume: assert property (p_resume)
        else $error("resume event without force resume");
    property p_abort_len;
        $rose(o_txn_abort) |-> o_txn_abort [*8] ##1 !o_txn_abort;
    endproperty
    a_abort_len: assert property (p_abort_len)
        else $error("abort length wrong");
    property p_hcrst_done;
        $rose(o_txn_abort) |-> ##[6:10] !o_cmd_rdata[B_HCRST];
    endproperty
    a_hcrst_done: assert property (p_hcrst_done)
        else $error("soft reset bit stuck");
    property p_virt_disc;
        o_txn_abort && $past(o_txn_abort)
            |-> o_port_connect == '0 && o_port_lowspeed == '0 && o_port_enable == '0;
    endproperty
    a_virt_disc: assert property (p_virt_disc)
        else $error("port not disconnected in soft reset");
    property p_redetect;
        $fell(o_txn_abort) |-> (o_port_connect == '0) [*8];
    endproperty
    a_redetect: assert property (p_redetect)
        else $error("port redetect too early");
    property p_halt_idle;
        o_halted |-> !o_sched_run;
    endproperty
    a_halt_idle: assert property (p_halt_idle)
        else $error("schedule runs while halted");
    // Resets may halt mid transaction, so they are excluded here
    property p_halt_cause;
        $rose(o_halted) && !o_txn_abort && !$past(o_txn_abort) && !o_usb_reset
            && !$past(o_usb_reset) |-> !$past(i_txn_active);
    endproperty
    a_halt_cause: assert property (p_halt_cause)
        else $error("halted during a transaction");
    property p_fatal;
        i_err_consist || i_err_pci |-> ##2 !o_cmd_rdata[B_RS];
    endproperty
    a_fatal: assert property (p_fatal)
        else $error("fatal error left run set");
    property p_step;
        o_cmd_rdata[B_DBG] && i_td_fetch |-> ##2 !o_cmd_rdata[B_RS];
    endproperty
    a_step: assert property (p_step)
        else $error("single step left run set");
    property p_bus_wide_reset_cmd;
        o_usb_reset && $past(o_usb_reset) |-> o_halted && !o_sched_run && o_port_connect == '0;
    endproperty
    a_bus_wide_reset_cmd: assert property (p_bus_wide_reset_cmd)
        else $error("logic active in global reset");
    property p_sof_start;
        $rose(o_sched_run) && !o_cmd_rdata[B_DBG] |-> o_sof;
    endproperty
    a_sof_start: assert property (p_sof_start)
        else $error("normal run without start of frame");
endmodule

bind uhrc_top uhrc_run_checker #(.FRAME_CYCLES(FRAME_CYCLES)) i_uhrc_run_checker (
    .i_clock, .i_rst, .o_cmd_rdata, .o_halted, .i_txn_active, .i_td_fetch,
    .i_err_consist, .i_err_pci, .o_sched_run, .o_sof, .o_txn_abort, .o_usb_reset,
    .o_global_resume, .o_resume_irq, .o_suspended, .o_port_connect,
    .o_port_enable, .o_port_lowspeed
);
`default_nettype wire

// ---- testbench/usb_host_run_control_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module usb_host_run_control_test
    import uhrc_pkg::*;
;
    localparam int FR = 50;
    logic i_clock, i_rst, i_cmd_wr, i_frame_index_reg_wr, i_txn_active, i_td_fetch, i_err_consist;
    logic i_err_pci, i_k_state, o_halted, o_sched_run, o_sof, o_txn_abort, o_usb_reset;
    logic o_global_resume, o_resume_irq, o_suspended, wake;
    logic [CMD_W-1:0] i_cmd_wdata, i_frame_index_reg_wdata, o_cmd_rdata;
    logic [FRIDX_W-1:0] o_frame_index, fidx;
    logic [NPORTS-1:0] i_port_attach, i_port_lowspeed, i_port_en_wr, i_port_en_val;
    logic [NPORTS-1:0] i_port_cc_clr, i_port_ec_clr, o_port_connect, o_port_conn_chg;
    logic [NPORTS-1:0] o_port_enable, o_port_en_chg, o_port_lowspeed, plug, slow;
    int fails = 0;
    int tests_run = 0;

    uhrc_top #(.FRAME_CYCLES(FR)) i_uhrc_top (
        .i_clock, .i_rst, .i_cmd_wr, .i_cmd_wdata, .o_cmd_rdata, .i_frame_index_reg_wr,
        .i_frame_index_reg_wdata, .o_frame_index, .o_halted, .i_txn_active, .i_td_fetch,
        .i_err_consist, .i_err_pci, .o_sched_run, .o_sof, .o_txn_abort, .o_usb_reset,
        .o_global_resume, .o_resume_irq, .o_suspended, .i_k_state, .i_port_attach,
        .i_port_lowspeed, .i_port_en_wr, .i_port_en_val, .i_port_cc_clr, .i_port_ec_clr,
        .o_port_connect, .o_port_conn_chg, .o_port_enable, .o_port_en_chg, .o_port_lowspeed
    );
    uhrc_dev_model i_uhrc_dev_model (
        .i_clock, .i_plug(plug), .i_slow(slow), .i_wake(wake),
        .o_attach(i_port_attach), .o_lowspeed(i_port_lowspeed), .o_k_state(i_k_state)
    );

    // ==============================
    // Clock and helper tasks
    // ==============================
    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge i_clock);
    endtask
    // Strobe drops a cycle before the next write may raise it
    task automatic wr(input logic [15:0] d);
        i_cmd_wr = 1'b1;
        i_cmd_wdata = d;
        tick(1);
        i_cmd_wr = 1'b0;
        tick(1);
    endtask
    // Bounded wait on halted (0) or the resume pulse (1)
    task automatic wait_sig(input int sel, input string what);
        int n;
        n = 0;
        while (((sel == 0) ? o_halted : o_resume_irq) !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        chk(what, 16'h0000, (n >= 200) ? 16'h0001 : 16'h0000);
        if (n >= 200) begin
            conclude();
        end
    endtask

    // ==============================
    // Main sequence
    // ==============================
    initial begin
        {i_rst, i_cmd_wr, i_frame_index_reg_wr, i_txn_active, i_td_fetch, i_err_consist} = 6'h20;
        {i_err_pci, wake, i_cmd_wdata, i_frame_index_reg_wdata} = '0;
        {i_port_en_wr, i_port_en_val, i_port_cc_clr, i_port_ec_clr} = '0;
        plug = 2'b11;
        slow = 2'b10;
        tick(20);
        chk("cmd reset", 16'h0000, o_cmd_rdata);
        chk("halted reset", 16'h0001, 16'(o_halted));
        i_rst = 1'b0;
        tick(80);
        chk("attach", 16'h000E, 16'({o_port_connect, o_port_lowspeed}));
        {i_port_cc_clr, i_port_ec_clr, i_port_en_wr, i_port_en_val} = 8'hFF;
        tick(1);
        {i_port_cc_clr, i_port_ec_clr, i_port_en_wr} = '0;
        tick(2);
        chk("ports enabled", 16'h0003, 16'({o_port_conn_chg, o_port_enable}));
        wr(16'h0001);
        chk("sof at start", 16'h0001, 16'(o_sof));
        chk("run readback", 16'h0001, o_cmd_rdata);
        fidx = o_frame_index;
        tick(FR + 5);
        chk("frame advance", 16'(fidx) + 16'h0001, 16'(o_frame_index));
        i_frame_index_reg_wr = 1'b1;
        tick(1);
        i_frame_index_reg_wr = 1'b0;
        chk("index locked", 16'(fidx) + 16'h0001, 16'(o_frame_index));
        i_txn_active = 1'b1;
        wr(16'h0000);
        tick(5);
        chk("halted while busy", 16'h0000, 16'(o_halted));
        i_txn_active = 1'b0;
        wait_sig(0, "stop halts");
        i_frame_index_reg_wr = 1'b1;
        i_frame_index_reg_wdata = 16'h0123;
        tick(1);
        i_frame_index_reg_wr = 1'b0;
        tick(1);
        chk("index write", 16'h0123, 16'(o_frame_index));
        wr(16'h0001);
        tick(FR - 3);
        chk("frame restarted", 16'h0123, 16'(o_frame_index));
        tick(5);
        chk("index next", 16'h0124, 16'(o_frame_index));
        wr(16'h0000);
        wait_sig(0, "stop again");
        wr(16'h0020);
        wr(16'h0021);
        i_txn_active = 1'b1;
        i_td_fetch = 1'b1;
        tick(1);
        i_td_fetch = 1'b0;
        tick(2);
        chk("step clears run", 16'h0020, o_cmd_rdata);
        chk("step busy", 16'h0000, 16'(o_halted));
        i_txn_active = 1'b0;
        wait_sig(0, "step halts");
        fidx = o_frame_index;
        tick(2 * FR);
        chk("frozen index", 16'(fidx), 16'(o_frame_index));
        wr(16'h0000);
        // Both fatal error sources in turn
        for (int k = 0; k < 2; k++) begin
            wr(16'h0001);
            tick(3);
            i_err_consist = (k == 0);
            i_err_pci = (k == 1);
            tick(1);
            {i_err_consist, i_err_pci} = 2'b00;
            tick(2);
            chk("fatal clears run", 16'h0000, o_cmd_rdata);
            wait_sig(0, "fatal halts");
        end
        wr(16'h0008);
        tick(2);
        chk("suspend idle", 16'h0002, 16'({o_suspended, o_sched_run}));
        wake = 1'b1;
        tick(1);
        wake = 1'b0;
        wait_sig(1, "resume irq");
        tick(2);
        chk("force resume", 16'h0018, o_cmd_rdata);
        chk("resume drive", 16'h0001, 16'(o_global_resume));
        wr(16'h0000);
        tick(2);
        chk("suspend left", 16'h0000, 16'(o_suspended));
        wr(16'h00C0);
        chk("cfg bits", 16'h00C0, o_cmd_rdata);
        wr(16'h0002);
        tick(1);
        chk("soft reset run", 16'h0005, {o_cmd_rdata[14:0], o_txn_abort});
        chk("virtual off", 16'h0000, 16'({o_port_connect, o_port_lowspeed, o_port_enable}));
        chk("change flags", 16'h000F, 16'({o_port_conn_chg, o_port_en_chg}));
        tick(10);
        chk("self clear", 16'h0000, o_cmd_rdata);
        tick(40);
        chk("no early detect", 16'h0000, 16'(o_port_connect));
        tick(30);
        chk("redetect", 16'h000E, 16'({o_port_connect, o_port_lowspeed}));
        wr(16'h0001);
        wr(16'h0004);
        tick(3);
        chk("bus reset", 16'h0003, 16'({o_usb_reset, o_halted}));
        chk("hub cleared", 16'h0000, 16'({o_port_connect, o_port_conn_chg}));
        chk("index cleared", 16'h0000, 16'(o_frame_index));
        // Held short: a full ten ms would exceed the run budget
        tick(200);
        wr(16'h0000);
        tick(2);
        chk("bus reset end", 16'h0000, 16'(o_usb_reset));
        tick(100);
        wr(16'h0001);
        tick(5);
        i_rst = 1'b1;
        tick(2);
        chk("chip reset cmd", 16'h0000, o_cmd_rdata);
        chk("chip reset quiet", 16'h0001, 16'({o_usb_reset, o_halted}));
        conclude();
    end
endmodule
`default_nettype wire
